/* hdl/acs_pkg.sv */
// Constants, types and helpers shared by the conversion sequencer files.
`default_nettype none
package acs_pkg;
   // ===========================================================
   // Widths and register map
   localparam int           DATA_W        = 10;
   localparam int           REG_W         = 8;
   localparam int           CH_W          = 3;
   localparam int           FIFO_DEPTH    = 16;
   localparam int           IDX_HI        = 9;
   localparam int           IDX_LO        = 8;
   localparam logic [1:0]   IDX_MODE      = 2'h0;
   localparam logic [1:0]   IDX_AUX       = 2'h1;
   localparam logic [7:0]   MODE_RST      = 8'h00;
   localparam logic [7:0]   AUX_RST       = 8'h00;
   // ===========================================================
   // Field positions
   localparam int           MODE_SW_BIT   = 7;
   localparam int           MODE_EOC_BIT  = 6;
   localparam int           MODE_SWP_BIT  = 3;
   localparam int           MODE_CH_HI    = 2;
   localparam int           AUX_OSC_BIT   = 6;
   localparam int           AUX_FMT_BIT   = 3;
   localparam int           AUX_RB_BIT    = 2;
   localparam int           AUX_ST_HI     = 1;
   localparam int           AUX_ST_LO     = 0;
   localparam logic [7:0]   AUX_RSVD_MASK = 8'hB0;
   // ===========================================================
   // Timing
   localparam int           CLK_HZ        = 50_000_000;
   localparam int           OSC_SLOW_HZ   = 10_000_000;
   localparam int           OSC_FAST_HZ   = 20_000_000;
   localparam logic [2:0]   DIV_SLOW_LAST = 3'((CLK_HZ + OSC_SLOW_HZ - 1) / OSC_SLOW_HZ - 1);
   localparam logic [2:0]   DIV_FAST_LAST = 3'((CLK_HZ + OSC_FAST_HZ - 1) / OSC_FAST_HZ - 1);
   localparam logic [3:0]   SAMPLE_CLKS   = 4'h6;
   localparam logic [3:0]   CONV_CLKS     = 4'hA;
   // ===========================================================
   // Self-test codes and states
   localparam logic [1:0]   ST_NONE       = 2'h0;
   localparam logic [9:0]   ST1_CODE      = 10'h000;
   localparam logic [9:0]   ST2_CODE      = 10'h200;
   localparam logic [9:0]   ST3_CODE      = 10'h3FF;
   typedef enum logic [2:0] {
      ACS_IDLE   = 3'b001,
      ACS_SAMPLE = 3'b010,
      ACS_CONV   = 3'b100
   } acs_state_e;
   // Result coding; two's complement is the binary code with its MSB flipped.
   function automatic logic [9:0] acs_format(input logic [9:0] code, input logic twos);
      acs_format = {code[9] ^ twos, code[8:0]};
   endfunction
endpackage
`default_nettype wire

/* hdl/acs_fifo_if.sv */
// Valid/ready channel carrying conversion results into the result FIFO.
`timescale 1ns/1ns
`default_nettype none
interface acs_fifo_if #(parameter int W = 10);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport src  (output in_valid, output in_data, input in_ready);
   modport fifo (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
   modport sink (input out_valid, input out_data, output out_ready);
endinterface // acs_fifo_if
`default_nettype wire

/* hdl/acs_fifo.sv */
// Result FIFO in flip-flops with valid/ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module acs_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input wire logic CLK,
   input wire logic RST,
   acs_fifo_if.fifo F
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;
   assign F.in_ready  = (count_r != (AW+1)'(DEPTH));
   assign F.out_valid = (count_r != '0);
   assign F.out_data  = mem_r[rd_ptr_r];
   assign push        = F.in_valid & F.in_ready;
   assign pop         = F.out_ready & F.out_valid;
   always_ff @(posedge CLK) begin
      if (push) begin
         mem_r[wr_ptr_r] <= F.in_data;
      end
   end
   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // acs_fifo
`default_nettype wire

/* hdl/acs_sync.sv */
// Three-stage pin synchroniser; a bit changes once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module acs_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         CLK,
   input  wire logic         RST,
   input  wire logic [W-1:0] D,
   output logic      [W-1:0] Q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   always_ff @(posedge CLK) begin
      if (RST) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         Q    <= RST_VAL;
      end else begin
         s1_r <= D;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               Q[i] <= s3_r[i];
            end
         end
      end
   end
endmodule // acs_sync
`default_nettype wire

/* hdl/acs_top.sv */
// Conversion sequencer: control registers, start logic, result path and data port.
`timescale 1ns/1ns
`default_nettype none
module acs_top (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       CS_N,
   input  wire logic       RD_N,
   input  wire logic       WR_N,
   input  wire logic       CONV_TRIGGER_N,
   input  wire logic [9:0] D_IN,
   output logic      [9:0] D_OUT,
   output logic            D_OE,
   input  wire logic [9:0] ADC_CODE,
   output logic            RESULT_N,
   output logic      [2:0] CH_SEL,
   output logic            SAMPLE_HOLD,
   output logic      [1:0] SELF_TEST_SEL,
   output logic            OSC_FAST,
   output logic            CONFIGURED
);
   // ===========================================================
   // Pin synchronisation and strobe edges
   logic [3:0] pins_s;
   logic [9:0] din_s;
   logic       cs_n_s;
   logic       rd_n_s;
   logic       wr_n_s;
   logic       trig_n_s;
   logic       rd_n_d_r;
   logic       wr_n_d_r;
   logic       trig_n_d_r;
   logic       wr_cmd_d_r;
   logic       rd_rise;
   logic       wr_rise;
   logic       trig_fall;
   logic       trig_rise;
   logic       self_cfg;
   logic       wr_cmd;

   // Data rides the same three stages as the strobes so both stay aligned.
   acs_sync #(.W(4), .RST_VAL(4'hF)) u_sync_ctl (
      .CLK (CLK),
      .RST (RST),
      .D   ({CS_N, RD_N, WR_N, CONV_TRIGGER_N}),
      .Q   (pins_s)
   );
   acs_sync #(.W(10), .RST_VAL(10'h000)) u_sync_dat (
      .CLK (CLK),
      .RST (RST),
      .D   (D_IN),
      .Q   (din_s)
   );
   assign {cs_n_s, rd_n_s, wr_n_s, trig_n_s} = pins_s;

   always_ff @(posedge CLK) begin
      if (RST) begin
         rd_n_d_r   <= 1'b1;
         wr_n_d_r   <= 1'b1;
         trig_n_d_r <= 1'b1;
         wr_cmd_d_r <= 1'b0;
      end else begin
         rd_n_d_r   <= rd_n_s;
         wr_n_d_r   <= wr_n_s;
         trig_n_d_r <= trig_n_s;
         wr_cmd_d_r <= wr_cmd;
      end
   end
   assign rd_rise   = rd_n_s & ~rd_n_d_r & ~cs_n_s;
   assign wr_rise   = wr_n_s & ~wr_n_d_r & ~cs_n_s;
   assign trig_fall = ~trig_n_s & trig_n_d_r;
   assign trig_rise = trig_n_s & ~trig_n_d_r;
   assign self_cfg  = rd_rise & ~wr_n_s;
   assign wr_cmd    = wr_rise;

   // ===========================================================
   // Control registers
   logic [7:0] mode_control_reg_r;
   logic [7:0] aux_control_reg_r;
   logic       configured_r;
   logic       sw_start;
   logic       eoc_mode;
   logic       sweep_mode;
   logic [2:0] ch_field;
   logic       osc_speed_sel;
   logic       output_format_sel;
   logic       readback_sel;
   logic [1:0] self_test_sel;

   always_ff @(posedge CLK) begin
      if (RST) begin
         mode_control_reg_r <= acs_pkg::MODE_RST;
         aux_control_reg_r  <= acs_pkg::AUX_RST;
         configured_r       <= 1'b0;
      end else if (self_cfg) begin
         mode_control_reg_r <= acs_pkg::MODE_RST;
         aux_control_reg_r  <= acs_pkg::AUX_RST;
         configured_r       <= 1'b1;
      end else if (wr_cmd) begin
         configured_r <= 1'b1;
         if (din_s[acs_pkg::IDX_HI:acs_pkg::IDX_LO] == acs_pkg::IDX_MODE) begin
            mode_control_reg_r <= din_s[7:0];
         end
         // Reserved aux bits are forced to zero so readback stays predictable.
         if (din_s[acs_pkg::IDX_HI:acs_pkg::IDX_LO] == acs_pkg::IDX_AUX) begin
            aux_control_reg_r <= din_s[7:0] & ~acs_pkg::AUX_RSVD_MASK;
         end
      end
   end
   assign sw_start          = mode_control_reg_r[acs_pkg::MODE_SW_BIT];
   assign eoc_mode          = mode_control_reg_r[acs_pkg::MODE_EOC_BIT];
   assign sweep_mode        = mode_control_reg_r[acs_pkg::MODE_SWP_BIT];
   assign ch_field          = mode_control_reg_r[acs_pkg::MODE_CH_HI:0];
   assign osc_speed_sel     = aux_control_reg_r[acs_pkg::AUX_OSC_BIT];
   assign output_format_sel = aux_control_reg_r[acs_pkg::AUX_FMT_BIT];
   assign readback_sel      = aux_control_reg_r[acs_pkg::AUX_RB_BIT];
   assign self_test_sel     = aux_control_reg_r[acs_pkg::AUX_ST_HI:acs_pkg::AUX_ST_LO];

   // ===========================================================
   // Conversion clock enable
   logic [2:0] div_cnt_r;
   logic [2:0] div_last;
   logic       tick_r;

   assign div_last = osc_speed_sel ? acs_pkg::DIV_FAST_LAST : acs_pkg::DIV_SLOW_LAST;
   always_ff @(posedge CLK) begin
      if (RST) begin
         div_cnt_r <= 3'h0;
         tick_r    <= 1'b0;
      end else if (div_cnt_r >= div_last) begin
         div_cnt_r <= 3'h0;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 3'h1;
         tick_r    <= 1'b0;
      end
   end

   // ===========================================================
   // Sequencer
   acs_fifo_if #(.W(acs_pkg::DATA_W)) res_q ();
   acs_pkg::acs_state_e state_r;
   acs_pkg::acs_state_e state_nxt;
   logic [3:0] cnt_r;
   logic       conv_done_r;
   logic       push;
   logic       start_req;

   // Software start: a write opens the first sample, later samples open on read.
   // The write is seen one cycle late so that the mode it just stored already applies.
   assign start_req = sw_start ? (wr_cmd_d_r | rd_rise) : trig_fall;
   assign push      = conv_done_r & res_q.in_ready;
   assign res_q.in_valid = conv_done_r;
   assign res_q.in_data  = ADC_CODE;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         acs_pkg::ACS_IDLE: begin
            if (start_req && !self_cfg) begin
               state_nxt = acs_pkg::ACS_SAMPLE;
            end
         end
         acs_pkg::ACS_SAMPLE: begin
            if (!sw_start && trig_rise) begin
               state_nxt = acs_pkg::ACS_CONV;
            end else if (sw_start && tick_r && cnt_r == acs_pkg::SAMPLE_CLKS - 4'h1) begin
               state_nxt = acs_pkg::ACS_CONV;
            end
         end
         acs_pkg::ACS_CONV: begin
            if (push) begin
               state_nxt = acs_pkg::ACS_IDLE;
            end
         end
         default: state_nxt = acs_pkg::ACS_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r <= acs_pkg::ACS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // A full FIFO holds the finished conversion until the host drains a result.
   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt_r       <= 4'h0;
         conv_done_r <= 1'b0;
      end else if (state_r != state_nxt) begin
         cnt_r       <= 4'h0;
         conv_done_r <= 1'b0;
      end else if (state_r == acs_pkg::ACS_CONV) begin
         if (tick_r && !conv_done_r) begin
            cnt_r <= cnt_r + 4'h1;
            conv_done_r <= (cnt_r == acs_pkg::CONV_CLKS - 4'h1);
         end
      end else if (state_r == acs_pkg::ACS_SAMPLE && tick_r) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   // ===========================================================
   // Channel selection
   logic [2:0] ch_r;
   always_ff @(posedge CLK) begin
      if (RST) begin
         ch_r <= 3'h0;
      end else if (!sweep_mode) begin
         ch_r <= ch_field;
      end else if (wr_cmd_d_r || self_cfg) begin
         ch_r <= 3'h0;
      end else if (push) begin
         ch_r <= (ch_r >= ch_field) ? 3'h0 : ch_r + 3'h1;
      end
   end

   // ===========================================================
   // Data port and result signalling
   logic       rd_active;
   logic [9:0] rd_word;
   assign rd_active       = ~cs_n_s & ~rd_n_s;
   assign res_q.out_ready = rd_rise & ~readback_sel;

   always_comb begin
      rd_word = 10'h000;
      if (readback_sel) begin
         if (self_test_sel == acs_pkg::ST_NONE) begin
            rd_word = {2'h0, mode_control_reg_r};
         end else if (self_test_sel == 2'h1) begin
            rd_word = {2'h0, aux_control_reg_r};
         end
      end else begin
         case (self_test_sel)
            2'h0:    rd_word = res_q.out_valid ? res_q.out_data : 10'h000;
            2'h1:    rd_word = acs_pkg::ST1_CODE;
            2'h2:    rd_word = acs_pkg::ST2_CODE;
            2'h3:    rd_word = acs_pkg::ST3_CODE;
            default: rd_word = 10'h000;
         endcase
         rd_word = acs_pkg::acs_format(rd_word, output_format_sel);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         D_OUT <= 10'h000;
         D_OE  <= 1'b0;
      end else begin
         D_OUT <= rd_word;
         D_OE  <= rd_active;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RESULT_N <= 1'b1;
      end else if (eoc_mode) begin
         RESULT_N <= ~(state_nxt == acs_pkg::ACS_CONV);
      end else begin
         RESULT_N <= ~push;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         CH_SEL        <= 3'h0;
         SAMPLE_HOLD   <= 1'b0;
         SELF_TEST_SEL <= 2'h0;
         OSC_FAST      <= 1'b0;
         CONFIGURED    <= 1'b0;
      end else begin
         CH_SEL        <= ch_r;
         SAMPLE_HOLD   <= (state_r == acs_pkg::ACS_SAMPLE);
         SELF_TEST_SEL <= self_test_sel;
         OSC_FAST      <= osc_speed_sel;
         CONFIGURED    <= configured_r;
      end
   end

   acs_fifo #(.WIDTH(acs_pkg::DATA_W), .DEPTH(acs_pkg::FIFO_DEPTH)) u_fifo (
      .CLK (CLK),
      .RST (RST),
      .F   (res_q)
   );

   // ===========================================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   self_cfg_zero_a: assert property (self_cfg |=> mode_control_reg_r == 8'h00 && aux_control_reg_r == 8'h00)
      else $error("self-configuration did not clear the control registers");
   cfg_mark_a: assert property (self_cfg |=> ##1 CONFIGURED)
      else $error("self-configuration not reported");
   hw_conv_start_a: assert property (!sw_start && state_r == acs_pkg::ACS_SAMPLE && trig_rise
                                     |=> state_r == acs_pkg::ACS_CONV)
      else $error("trigger rise did not start conversion");
   sw_sample_len_a: assert property (sw_start && $changed(state_r) && state_r == acs_pkg::ACS_CONV
                                     |-> $past(cnt_r) == 4'h5)
      else $error("software sample period not six clocks");
   conv_len_a: assert property ($rose(conv_done_r) |-> cnt_r == 4'hA)
      else $error("conversion did not last ten clocks");
   int_pulse_a: assert property (!eoc_mode && push ##1 !eoc_mode |-> !RESULT_N ##1 RESULT_N)
      else $error("result pulse not one cycle wide");
   eoc_level_a: assert property (eoc_mode && state_r == acs_pkg::ACS_CONV && !push ##1 eoc_mode
                                 |-> !RESULT_N)
      else $error("conversion done held high during conversion");
   sweep_wrap_a: assert property (sweep_mode && push && ch_r >= ch_field && !wr_cmd_d_r && !self_cfg
                                  |=> ch_r == 3'h0)
      else $error("sweep did not wrap to channel zero");
   readback_cr_a: assert property (readback_sel && self_test_sel == 2'h0 ##1 readback_sel
                                   |-> D_OUT == {2'h0, $past(mode_control_reg_r)})
      else $error("readback did not present the mode register");
   single_ch_a: assert property (!sweep_mode |=> ch_r == $past(ch_field))
      else $error("single channel mode moved off the selected channel");
endmodule // acs_top
`default_nettype wire

/* bench/acs_host.sv */
// Host processor model that drives the converter's parallel port and trigger pin.
`timescale 1ns/1ns
`default_nettype none
module acs_host (
   input  wire logic       clk,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic            trig_n,
   output logic      [9:0] d_in,
   input  wire logic [9:0] d_out
);
   // Eight clocks per strobe phase keeps every edge clear of the three-stage pin synchroniser.
   localparam int HOLD = 8;
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      trig_n = 1'b1;
      d_in = 10'h155;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [1:0] idx, input logic [7:0] val);
      @(posedge clk);
      cs_n <= 1'b0;
      d_in <= {idx, val};
      wr_n <= 1'b0;
      wait_clk(HOLD);
      wr_n <= 1'b1;
      wait_clk(HOLD);
      cs_n <= 1'b1;
      // A released bus must not keep showing the last word.
      d_in <= ~{idx, val};
   endtask
   task automatic rd(output logic [9:0] val);
      @(posedge clk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      wait_clk(HOLD);
      val = d_out;
      rd_n <= 1'b1;
      wait_clk(HOLD);
      cs_n <= 1'b1;
   endtask
   task automatic self_config();
      @(posedge clk);
      wr_n <= 1'b0;
      cs_n <= 1'b0;
      wait_clk(HOLD);
      rd_n <= 1'b0;
      wait_clk(HOLD);
      rd_n <= 1'b1;
      wait_clk(HOLD);
      cs_n <= 1'b1;
      wait_clk(HOLD);
      wr_n <= 1'b1;
      wait_clk(HOLD);
   endtask
   task automatic trig(input int low_clks);
      @(posedge clk);
      trig_n <= 1'b0;
      wait_clk(low_clks);
      trig_n <= 1'b1;
   endtask
endmodule // acs_host
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int LIMIT = 20000;
   logic       clk;
   logic       rst;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic       trig_n;
   logic [9:0] d_in;
   logic [9:0] d_out;
   logic       d_oe;
   logic [9:0] adc_code;
   logic       result_n;
   logic [2:0] ch_sel;
   logic       sample_hold;
   logic [1:0] st_sel;
   logic       osc_fast;
   logic       configured;
   logic [9:0] got;
   logic [9:0] q[$];
   logic [7:0] v;
   int         err_total = 0;
   int         tests_run = 0;
   int         cycles = 0;
   int         seed;
   int         lat;
   int         wid;

   acs_host u_acs_host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .trig_n(trig_n),
                        .d_in(d_in), .d_out(d_out));
   acs_top u_acs_top (.CLK(clk), .RST(rst), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
                      .CONV_TRIGGER_N(trig_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe),
                      .ADC_CODE(adc_code), .RESULT_N(result_n), .CH_SEL(ch_sel),
                      .SAMPLE_HOLD(sample_hold), .SELF_TEST_SEL(st_sel), .OSC_FAST(osc_fast),
                      .CONFIGURED(configured));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // =========================================================
   // Compare and closing tasks
   task automatic chk_val(input string name, input logic [9:0] exp, input logic [9:0] seen);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic chk_cnt(input string name, input int lo, input int hi, input int seen);
      tests_run++;
      if (seen < lo || seen > hi) begin
         err_total++;
         $display("FAIL %s expected %0d to %0d seen %0d", name, lo, hi, seen);
      end
   endtask
   task automatic results();
      $display("Checks made %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Latency to the first low cycle of the result output and how long it stays low.
   task automatic await_result(input int limit, output int l, output int w);
      l = -1;
      w = 0;
      for (int n = 0; n < limit && l < 0; n++) begin
         @(posedge clk);
         if (result_n === 1'b0) begin
            l = n;
         end
      end
      while (l >= 0 && result_n === 1'b0 && w < 100) begin
         @(posedge clk);
         w++;
      end
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         results();
      end
   end

   // =========================================================
   // Main sequence
   initial begin
      seed = 69128;
      rst = 1'b1;
      adc_code = 10'h000;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk_val("configured", 10'h000, {9'h0, configured});
      u_acs_host.self_config();
      chk_val("configured", 10'h001, {9'h0, configured});
      chk_val("osc_fast", 10'h000, {9'h0, osc_fast});
      u_acs_host.wr(acs_pkg::IDX_AUX, 8'h04);
      u_acs_host.rd(got);
      chk_val("mode_reg", 10'h000, got);
      // Reserved aux bits are written with random values on purpose; only the defined bits are compared.
      v = (8'($random(seed)) & 8'hF8) | 8'h05;
      u_acs_host.wr(acs_pkg::IDX_AUX, v);
      u_acs_host.rd(got);
      chk_val("aux_reg", {2'h0, v & ~acs_pkg::AUX_RSVD_MASK}, got & {2'h0, ~acs_pkg::AUX_RSVD_MASK});
      chk_val("osc_fast", {9'h0, v[6]}, {9'h0, osc_fast});
      chk_val("st_sel", 10'h001, {8'h0, st_sel});
      v = 8'($random(seed)) & 8'h7F;
      u_acs_host.wr(acs_pkg::IDX_MODE, v);
      u_acs_host.wr(acs_pkg::IDX_AUX, 8'h04);
      u_acs_host.rd(got);
      chk_val("mode_reg", {2'h0, v}, got);
      for (int f = 0; f < 2; f++) begin
         for (int s = 1; s < 4; s++) begin
            u_acs_host.wr(acs_pkg::IDX_AUX, 8'(f * 8 + s));
            u_acs_host.rd(got);
            chk_val("self_test", (s == 1 ? 10'h000 : s == 2 ? 10'h200 : 10'h3FF) ^ 10'(f * 512), got);
         end
      end
      // Seventeen triggers without reads: the last result has to wait for room in the FIFO.
      u_acs_host.wr(acs_pkg::IDX_MODE, 8'h05);
      u_acs_host.wr(acs_pkg::IDX_AUX, 8'h00);
      for (int i = 0; i < 17; i++) begin
         adc_code <= 10'($random(seed));
         u_acs_host.trig(8 + i);
         await_result(150, lat, wid);
         q.push_back(adc_code);
         chk_val("ch_sel", 10'h005, {7'h0, ch_sel});
         if (i < 16) begin
            chk_cnt("pulse_lat", 45, 64, lat);
            chk_cnt("pulse_wid", 1, 1, wid);
         end else begin
            chk_cnt("stall_lat", -1, -1, lat);
         end
         u_acs_host.wait_clk(8);
      end
      for (int i = 0; i < 17; i++) begin
         u_acs_host.rd(got);
         chk_val("fifo_data", q.pop_front(), got);
      end
      // Software-start sweep over channels 0 to 2 with the end-of-conversion signal.
      u_acs_host.wr(acs_pkg::IDX_AUX, 8'h08);
      adc_code <= 10'($random(seed));
      u_acs_host.wr(acs_pkg::IDX_MODE, 8'hCA);
      for (int k = 0; k < 4; k++) begin
         chk_val("sampling", 10'h001, {9'h0, sample_hold});
         chk_val("ch_sel", 10'(k % 3), {7'h0, ch_sel});
         await_result(100, lat, wid);
         chk_cnt("eoc_wid", 46, 56, wid);
         u_acs_host.rd(got);
         chk_val("sweep_data", adc_code ^ 10'h200, got);
         adc_code <= 10'($random(seed));
      end
      results();
   end
endmodule // tb_top
`default_nettype wire
